// ===== rtl/ldac_pkg.sv
// Constants, field layouts and carrier types for the ladder converter control.
// Assumes one 100 MHz clock and a plain register port with read data one cycle later.
//
// How it works
// - Bit 7 of main control turns the converter on; zero holds it off.
// - A 5-bit level code picks one of 32 ladder taps.
// - Bits 3-2 pick positive source: supply, reference pin, fixed reference; 11 reserved.
// - Bit 5 routes the level to pin one; zero disconnects it.
// - Bit 4 routes the level to pin two; zero disconnects it.
// - A routed pin loses digital driver, input detector, pull-up and current drive.
// - Digital reads of a routed pin return zero.
// - Sleep and wake-up leave the converter running and controls untouched.
// - Reset disables converter, unroutes both pins, clears the level code.
// - Main control bits 6, 1 and 0 read as zero.
// - Level code sits in bits 4-0 of level select; bits 7-5 read zero.
package ldac_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses of our own choosing
	localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_LEVEL_SELECT = 4'h1;

	// Field positions in main control
	localparam int BIT_CONVERTER_ON     = 7;
	localparam int BIT_LEVEL_TO_PIN_ONE = 5;
	localparam int BIT_LEVEL_TO_PIN_TWO = 4;
	localparam int BIT_POS_SRC_HI       = 3;
	localparam int BIT_POS_SRC_LO       = 2;

	// Reset values
	localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
	localparam logic [4:0] RST_LEVEL_CODE   = 5'h00;
	localparam logic [7:0] READ_ZERO        = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Positive source selection codes
	typedef enum logic [1:0] {
		LDAC_SRC_SUPPLY    = 2'h0,
		LDAC_SRC_REF_PIN   = 2'h1,
		LDAC_SRC_FIXED_REF = 2'h2,
		LDAC_SRC_RESERVED  = 2'h3
	} ldac_src_e;

	// One-hot source enables toward the ladder top switch
	typedef struct packed {
		logic supply;
		logic ref_pin;
		logic fixed_ref;
	} ldac_src_sel_s;

	// Overrides handed to one pad
	typedef struct packed {
		logic analog_route;
		logic dig_out_off;
		logic dig_in_off;
		logic pullup_off;
		logic cur_drive_off;
	} ldac_pad_ctl_s;

	// Software-visible control state
	typedef struct packed {
		logic      converter_on;
		logic      level_to_pin_one;
		logic      level_to_pin_two;
		ldac_src_e positive_source_sel;
		logic [4:0] level_code;
	} ldac_ctl_s;

endpackage

// ===== rtl/ldac_pad_ovr.sv
// Pad override for one converter output pin.
// Assumes the pad follows these enables combinationally; the parent registers them.
`timescale 1ns/1ps

module ldac_pad_ovr (
	// Control
	input  wire logic                   route_i,
	input  wire logic                   pin_in_i,
	// Results
	output      ldac_pkg::ldac_pad_ctl_s ctl_o,
	output      logic                   pin_read_o
);

	// A routed pin gives up every digital function so the ladder sees a quiet node
	always_comb begin
		ctl_o.analog_route  = route_i;
		ctl_o.dig_out_off   = route_i;
		ctl_o.dig_in_off    = route_i;
		ctl_o.pullup_off    = route_i;
		ctl_o.cur_drive_off = route_i;
	end

	// Masking here keeps a floating analog level from reaching core logic
	assign pin_read_o = pin_in_i & ~route_i;

endmodule

// ===== rtl/ldac_top.sv
// Ladder converter control: registers, source decode, tap select and pin overrides.
// Assumes a plain register port, strobes synchronous to sys_clk_i, never both at once.
`timescale 1ns/1ps

module ldac_top (
	// Clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    nrst_i,
	// Register port
	input  wire logic [3:0]              reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output      logic [7:0]              reg_rdata_o,
	// Power state, informative only
	input  wire logic                    sleep_i,
	// Raw digital levels of the two pins
	input  wire logic                    pin_one_in_i,
	input  wire logic                    pin_two_in_i,
	// Ladder controls
	output      logic                    converter_on_o,
	output      ldac_pkg::ldac_src_sel_s pos_src_o,
	output      logic [31:0]             tap_sel_o,
	output      logic [4:0]              level_code_o,
	// Pin controls
	output      ldac_pkg::ldac_pad_ctl_s analog_out_pin_one_o,
	output      ldac_pkg::ldac_pad_ctl_s analog_out_pin_two_o,
	output      logic                    pin_one_read_o,
	output      logic                    pin_two_read_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Module state
	typedef struct packed {
		ldac_pkg::ldac_ctl_s     ctl;
		logic [7:0]              rdata;
		logic                    on;
		ldac_pkg::ldac_src_sel_s src;
		logic [31:0]             tap;
		logic [4:0]              code;
		ldac_pkg::ldac_pad_ctl_s pad_one;
		ldac_pkg::ldac_pad_ctl_s pad_two;
		logic                    read_one;
		logic                    read_two;
	} ldac_state_s;

	ldac_state_s state_reg;
	ldac_state_s state_next;

	ldac_pkg::ldac_pad_ctl_s pad_one_c;
	ldac_pkg::ldac_pad_ctl_s pad_two_c;
	logic                    read_one_c;
	logic                    read_two_c;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Readback image of main control; bits 6, 1 and 0 always zero
	function automatic logic [7:0] main_image(input ldac_pkg::ldac_ctl_s c);
		logic [7:0] v;
		v = ldac_pkg::READ_ZERO;
		v[ldac_pkg::BIT_CONVERTER_ON]     = c.converter_on;
		v[ldac_pkg::BIT_LEVEL_TO_PIN_ONE] = c.level_to_pin_one;
		v[ldac_pkg::BIT_LEVEL_TO_PIN_TWO] = c.level_to_pin_two;
		v[ldac_pkg::BIT_POS_SRC_HI:ldac_pkg::BIT_POS_SRC_LO] = c.positive_source_sel;
		return v;
	endfunction

	// Source switch decode; the reserved code closes no switch so the ladder top floats
	// rather than shorting two references together
	function automatic ldac_pkg::ldac_src_sel_s src_decode(input ldac_pkg::ldac_src_e s);
		ldac_pkg::ldac_src_sel_s r;
		r = '0;
		case (s)
			ldac_pkg::LDAC_SRC_SUPPLY:    r.supply    = 1'b1;
			ldac_pkg::LDAC_SRC_REF_PIN:   r.ref_pin   = 1'b1;
			ldac_pkg::LDAC_SRC_FIXED_REF: r.fixed_ref = 1'b1;
			default:                      r           = '0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pad overrides, one per output pin
	ldac_pad_ovr u_pad_one (
		.route_i    (state_reg.ctl.level_to_pin_one),
		.pin_in_i   (pin_one_in_i),
		.ctl_o      (pad_one_c),
		.pin_read_o (read_one_c)
	);

	ldac_pad_ovr u_pad_two (
		.route_i    (state_reg.ctl.level_to_pin_two),
		.pin_in_i   (pin_two_in_i),
		.ctl_o      (pad_two_c),
		.pin_read_o (read_two_c)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	// Sleep is deliberately not an input to any term: controls and ladder keep running
	always_comb begin
		state_next = state_reg;

		// Register writes
		if (reg_wr_i) begin
			if (reg_addr_i == ldac_pkg::ADDR_MAIN_CONTROL) begin
				state_next.ctl.converter_on        =
					reg_wdata_i[ldac_pkg::BIT_CONVERTER_ON];
				state_next.ctl.level_to_pin_one    =
					reg_wdata_i[ldac_pkg::BIT_LEVEL_TO_PIN_ONE];
				state_next.ctl.level_to_pin_two    =
					reg_wdata_i[ldac_pkg::BIT_LEVEL_TO_PIN_TWO];
				state_next.ctl.positive_source_sel = ldac_pkg::ldac_src_e'(
					reg_wdata_i[ldac_pkg::BIT_POS_SRC_HI:ldac_pkg::BIT_POS_SRC_LO]);
			end else if (reg_addr_i == ldac_pkg::ADDR_LEVEL_SELECT) begin
				state_next.ctl.level_code = reg_wdata_i[4:0];
			end
		end

		// Register reads, data valid the cycle after the strobe only
		state_next.rdata = ldac_pkg::READ_ZERO;
		if (reg_rd_i) begin
			if (reg_addr_i == ldac_pkg::ADDR_MAIN_CONTROL) begin
				state_next.rdata = main_image(state_reg.ctl);
			end else if (reg_addr_i == ldac_pkg::ADDR_LEVEL_SELECT) begin
				state_next.rdata = {3'h0, state_reg.ctl.level_code};
			end else begin
				state_next.rdata = ldac_pkg::READ_ZERO;
			end
		end

		// Outputs follow the stored controls one edge after a write lands
		state_next.on   = state_reg.ctl.converter_on;
		state_next.src  = src_decode(state_reg.ctl.positive_source_sel);
		state_next.code = state_reg.ctl.level_code;
		// Tap k of 32 gives negative source plus span times k/32; off keeps all taps open
		state_next.tap  = state_reg.ctl.converter_on ?
			(32'h0000_0001 << state_reg.ctl.level_code) : 32'h0000_0000;
		state_next.pad_one  = pad_one_c;
		state_next.pad_two  = pad_two_c;
		state_next.read_one = read_one_c;
		state_next.read_two = read_two_c;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; reset clears controls and unroutes both pins
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg     <= '0;
			// Each field taken from its own bit so the reset image follows the register map
			state_reg.ctl <= ldac_pkg::ldac_ctl_s'({
				ldac_pkg::RST_MAIN_CONTROL[ldac_pkg::BIT_CONVERTER_ON],
				ldac_pkg::RST_MAIN_CONTROL[ldac_pkg::BIT_LEVEL_TO_PIN_ONE],
				ldac_pkg::RST_MAIN_CONTROL[ldac_pkg::BIT_LEVEL_TO_PIN_TWO],
				ldac_pkg::RST_MAIN_CONTROL[ldac_pkg::BIT_POS_SRC_HI:ldac_pkg::BIT_POS_SRC_LO],
				ldac_pkg::RST_LEVEL_CODE});
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops
	assign reg_rdata_o          = state_reg.rdata;
	assign converter_on_o       = state_reg.on;
	assign pos_src_o            = state_reg.src;
	assign tap_sel_o            = state_reg.tap;
	assign level_code_o         = state_reg.code;
	assign analog_out_pin_one_o = state_reg.pad_one;
	assign analog_out_pin_two_o = state_reg.pad_two;
	assign pin_one_read_o       = state_reg.read_one;
	assign pin_two_read_o       = state_reg.read_two;

endmodule

// ===== testbench/ldac_assertions.sv
// Checker for the ladder converter control, bound into ldac_top.
// Assumes only the top's ports; one clock, asynchronous active-low reset.
`timescale 1ns/1ps

module ldac_checker (
	// Clock, reset and register port
	input wire logic                    sys_clk_i,
	input wire logic                    nrst_i,
	input wire logic [3:0]              reg_addr_i,
	input wire logic [7:0]              reg_wdata_i,
	input wire logic                    reg_wr_i,
	input wire logic                    reg_rd_i,
	input wire logic [7:0]              reg_rdata_o,
	// Ladder and pin controls
	input wire logic                    converter_on_o,
	input wire ldac_pkg::ldac_src_sel_s pos_src_o,
	input wire logic [31:0]             tap_sel_o,
	input wire logic [4:0]              level_code_o,
	input wire ldac_pkg::ldac_pad_ctl_s analog_out_pin_one_o,
	input wire ldac_pkg::ldac_pad_ctl_s analog_out_pin_two_o,
	input wire logic                    pin_one_read_o,
	input wire logic                    pin_two_read_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////////////////////
	// Ladder taps follow enable and code
	tap_off_a: assert property (!converter_on_o |-> tap_sel_o == 32'h0)
		else $error("tap closed while off");
	tap_on_a: assert property (converter_on_o |-> tap_sel_o == 32'h1 << level_code_o)
		else $error("wrong tap");
	// Writes reach the outputs two edges after the strobe
	ctl_write_a: assert property (reg_wr_i && reg_addr_i == 4'h0 |-> ##2
		{converter_on_o, analog_out_pin_one_o.analog_route, analog_out_pin_two_o.analog_route}
		== $past({reg_wdata_i[7], reg_wdata_i[5:4]}, 2)) else $error("control not updated");
	lvl_write_a: assert property (reg_wr_i && reg_addr_i == 4'h1 |-> ##2
		level_code_o == $past(reg_wdata_i[4:0], 2)) else $error("level not updated");
	// Reserved source code closes no switch; fixed code picks only the fixed one
	src_rsv_a: assert property (reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[3:2] == 2'h3
		|-> ##2 pos_src_o == 3'h0) else $error("reserved source switched");
	src_fixed_a: assert property (reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[3:2] == 2'h2
		|-> ##2 pos_src_o == 3'h1) else $error("fixed source not picked");
	// A routed pin loses all digital functions and reads zero
	pad_one_a: assert property (analog_out_pin_one_o.analog_route |->
		analog_out_pin_one_o == 5'h1f && !pin_one_read_o) else $error("pin one not overridden");
	pad_two_a: assert property (analog_out_pin_two_o.analog_route |->
		analog_out_pin_two_o == 5'h1f && !pin_two_read_o) else $error("pin two not overridden");
	// Read data stand only after a read, reserved bits zero
	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data without read");
	main_rsv_a: assert property (reg_rd_i && reg_addr_i == 4'h0 |=>
		(reg_rdata_o & 8'h43) == 8'h00) else $error("main reserved bits set");
	lvl_rsv_a: assert property (reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o[7:5] == 3'h0)
		else $error("level reserved bits set");
	reset_clear_a: assert property ($rose(nrst_i) |-> {converter_on_o, level_code_o,
		analog_out_pin_one_o, analog_out_pin_two_o, tap_sel_o} == '0) else $error("reset left state");
endmodule

bind ldac_top ldac_checker u_chk (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .converter_on_o, .pos_src_o, .tap_sel_o, .level_code_o,
	.analog_out_pin_one_o, .analog_out_pin_two_o, .pin_one_read_o, .pin_two_read_o);

// ===== testbench/testbench.sv
// Self-checking bench for the ladder converter control.
// Assumes ldac_top alone; the bench drives every input and keeps a shadow of the registers.
`timescale 1ns/1ps

module testbench;
	logic                    sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, sleep_i, rd_d;
	logic                    pin_one_in_i, pin_two_in_i, converter_on_o;
	logic                    pin_one_read_o, pin_two_read_o;
	logic [3:0]              reg_addr_i;
	logic [7:0]              reg_wdata_i, reg_rdata_o, main_m, lvl_m, m, l;
	logic [31:0]             tap_sel_o;
	logic [4:0]              level_code_o;
	ldac_pkg::ldac_src_sel_s pos_src_o;
	ldac_pkg::ldac_pad_ctl_s pad_one, pad_two;
	logic [7:0]              exp_q[$];
	int                      n_mismatch, comparisons;

	ldac_top DUT (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .sleep_i, .pin_one_in_i, .pin_two_in_i, .converter_on_o, .pos_src_o,
		.tap_sel_o, .level_code_o, .analog_out_pin_one_o(pad_one), .analog_out_pin_two_o(pad_two),
		.pin_one_read_o, .pin_two_read_o);

	// 100 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus cycle; both strobes set every call so neither is driven twice in a step
	task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		reg_wr_i <= w;
		reg_rd_i <= r;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		if (r) exp_q.push_back(a == 4'h0 ? main_m : a == 4'h1 ? lvl_m : 8'h00);
		if (w && a == 4'h0) main_m = d & 8'hbc;
		if (w && a == 4'h1) lvl_m = d & 8'h1f;
		@(posedge sys_clk_i);
	endtask
	// Controls sampled mid-cycle, where registered outputs have settled
	task automatic chk_ctl();
		@(negedge sys_clk_i);
		cmp(converter_on_o, main_m[7]);
		cmp(tap_sel_o, main_m[7] ? 32'h1 << lvl_m[4:0] : 32'h0);
		cmp(level_code_o, lvl_m[4:0]);
		cmp(pos_src_o, main_m[3:2] == 2'h3 ? 3'h0 : 3'h4 >> main_m[3:2]);
		cmp(pad_one, {5{main_m[5]}});
		cmp(pad_two, {5{main_m[4]}});
		cmp(pin_one_read_o, pin_one_in_i & ~main_m[5]);
		cmp(pin_two_read_o, pin_two_in_i & ~main_m[4]);
		@(posedge sys_clk_i);
	endtask
	// Reset, then read both registers back and check the controls
	task automatic reset_check();
		nrst_i <= 1'b0;
		main_m = 8'h00;
		lvl_m = 8'h00;
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		cyc(1'b0, 1'b1, 4'h0, 8'h00);
		cyc(1'b0, 1'b1, 4'h1, 8'h00);
		cyc(1'b0, 1'b0, 4'h0, 8'h00);
		chk_ctl();
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read data stand one cycle after the strobe; compare with the oldest note
	always @(posedge sys_clk_i) rd_d <= reg_rd_i;
	always @(negedge sys_clk_i) begin
		// A result with no note behind it is a mismatch of its own
		if (rd_d === 1'b1 && exp_q.size() == 0) begin
			cmp(32'h0, 32'h1);
		end else if (rd_d === 1'b1) begin
			cmp(reg_rdata_o, exp_q.pop_front());
		end
	end
	// Main sequence
	initial begin
		{nrst_i, reg_wr_i, reg_rd_i, sleep_i, pin_one_in_i, pin_two_in_i} = '0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		n_mismatch = 0;
		comparisons = 0;
		void'($urandom(29318));
		reset_check();
		// Every source code, enable on and off, random level, pins and sleep
		for (int i = 0; i < 8; i++) begin
			m = 8'($urandom());
			l = 8'($urandom());
			m[7] = ~i[2];
			m[3:2] = i[1:0];
			// Each pin both routed and free at least once, so the override checks fire
			m[5:4] = {i[0], ~i[0]};
			sleep_i <= 1'($urandom());
			pin_one_in_i <= 1'($urandom());
			pin_two_in_i <= 1'($urandom());
			cyc(1'b1, 1'b0, 4'h0, m);
			cyc(1'b0, 1'b1, 4'h0, 8'h00);
			cyc(1'b1, 1'b0, 4'h1, l);
			cyc(1'b0, 1'b1, 4'h1, 8'h00);
			repeat (2) cyc(1'b0, 1'b0, 4'h0, 8'h00);
			chk_ctl();
		end
		// Unmapped places: writes vanish, reads give zero
		cyc(1'b1, 1'b0, 4'h2, 8'hff);
		cyc(1'b1, 1'b0, 4'hf, 8'hff);
		cyc(1'b0, 1'b1, 4'h7, 8'h00);
		cyc(1'b0, 1'b1, 4'h0, 8'h00);
		cyc(1'b0, 1'b0, 4'h0, 8'h00);
		chk_ctl();
		reset_check();
		// Every read note must have met its result
		cmp(32'(exp_q.size()), 32'h0);
		report_and_stop();
	end
endmodule
